// File: src/lqi_regs.svh
`ifndef LQI_REGS_SVH
`define LQI_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define LQI_IDX_STATUS 12'h871
`define LQI_IDX_STEP1 12'h8AD
`define LQI_IDX_STEP2 12'h8ED
`define LQI_IDX_STEP3 12'h8EF
`define LQI_IDX_STEP4 12'h8F0
`define LQI_IDX_STEP5 12'h8F1
`define LQI_IDX_STEP6 12'h8F2

// reset values of the six step registers
`define LQI_STEP1_RST 16'h3051
`define LQI_STEP2_RST 16'h3041
`define LQI_STEP3_RST 16'h3033
`define LQI_STEP4_RST 16'h3029
`define LQI_STEP5_RST 16'h2020
`define LQI_STEP6_RST 16'h2019

// field positions
`define LQI_HYST_MSB 15
`define LQI_HYST_LSB 12
`define LQI_WSEL_MSB 11
`define LQI_WSEL_LSB 10
`define LQI_THR_MSB 9
`define LQI_THR_LSB 0
`define LQI_WORST_MSB 7
`define LQI_WORST_LSB 5
`define LQI_LEVEL_MSB 3
`define LQI_LEVEL_LSB 1

// fixed edge between the two poorest levels
`define LQI_FLOOR_THR 11'h066

// timing: shortest window in microseconds and the clock rate in MHz
`define LQI_WIN_BASE_US 90
`define LQI_CLK_MHZ 200
`define LQI_WIN_BASE_CYC (`LQI_WIN_BASE_US * `LQI_CLK_MHZ)

`endif

// File: src/lqi_pkg.sv
package lqi_pkg;
  // measurement sequencer states
  typedef enum logic [0:0] {LQI_ACCUM, LQI_DIVIDE} lqi_state_t;
  // 3-bit quality code, 0 poorest, 7 best
  typedef logic [2:0] lqi_level_t;
  // mean square error sample
  typedef logic [9:0] lqi_mse_t;
endpackage : lqi_pkg

// File: src/lqi_link_quality.sv
// Overview of operation
// - 3-bit level, 0 above 102, 7 at or below 25
// - level derived from 10-bit receiver error value
// - status keeps poorest level since last read
// - window select picks 90/180/360/720 us accumulation
// - six writable thresholds, first resets to 51h
// - other thresholds reset 41h,33h,29h,20h,19h
// - 4-bit hysteresis per boundary, resets 3h/2h
`include "lqi_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module lqi_link_quality
  import lqi_pkg::*;
#(
  parameter int WIN_BASE_CYCLES = `LQI_WIN_BASE_CYC, // shortest window in clocks
  parameter int SUM_W = 28, // error sum width, holds the longest window
  parameter int CNT_W = 18 // sample count width
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lqi_mse_t mse_value,
  input wire logic mse_valid,
  output lqi_level_t quality_level,
  output lqi_level_t worst_level,
  output lqi_mse_t mse_average
);

  localparam int NSTEP = 6;

  // register slot of a byte address: 0 status, 1..6 steps, 7 unmapped
  function automatic logic [2:0] reg_slot(input logic [15:0] addr);
    logic [2:0] slot;
    slot = 3'h7;
    if (addr[1:0] == 2'h0) begin
      case (addr[15:2])
        14'(`LQI_IDX_STATUS): slot = 3'h0;
        14'(`LQI_IDX_STEP1): slot = 3'h1;
        14'(`LQI_IDX_STEP2): slot = 3'h2;
        14'(`LQI_IDX_STEP3): slot = 3'h3;
        14'(`LQI_IDX_STEP4): slot = 3'h4;
        14'(`LQI_IDX_STEP5): slot = 3'h5;
        14'(`LQI_IDX_STEP6): slot = 3'h6;
        default: slot = 3'h7;
      endcase
    end
    return slot;
  endfunction : reg_slot

  // reset image of a step register
  function automatic logic [15:0] step_reset(input int idx);
    logic [15:0] val;
    case (idx)
      0: val = `LQI_STEP1_RST;
      1: val = `LQI_STEP2_RST;
      2: val = `LQI_STEP3_RST;
      3: val = `LQI_STEP4_RST;
      4: val = `LQI_STEP5_RST;
      default: val = `LQI_STEP6_RST;
    endcase
    return val;
  endfunction : step_reset

  // new level with hysteresis: a boundary already crossed stays crossed
  // until the error exceeds threshold plus hysteresis, and a new one is
  // crossed only once the error sits hysteresis below its threshold
  function automatic lqi_level_t next_level(
    input lqi_mse_t mse,
    input lqi_level_t cur,
    input logic [NSTEP-1:0][9:0] th,
    input logic [NSTEP-1:0][3:0] hy
  );
    logic [10:0] edge_val;
    logic [10:0] hy_val;
    logic go;
    lqi_level_t cnt;
    cnt = 3'h0;
    // floor boundary has a fixed edge and no hysteresis
    go = ({1'b0, mse} <= `LQI_FLOOR_THR);
    if (go) cnt = 3'h1;
    // boundaries count only in an unbroken run from the poorest end, so
    // odd threshold settings can never lift a floor-band error off code 0
    for (int k = 0; k < NSTEP; k++) begin
      edge_val = {1'b0, th[k]};
      hy_val = {7'h00, hy[k]};
      if (3'(k + 1) < cur) begin
        if ({1'b0, mse} > edge_val + hy_val) go = 1'b0;
      end else begin
        if ({1'b0, mse} + hy_val > edge_val) go = 1'b0;
      end
      if (go) cnt = cnt + 3'h1;
    end
    return cnt;
  endfunction : next_level

  // configuration fields
  logic [NSTEP-1:0][9:0] thr; // boundary_threshold_1..6
  logic [NSTEP-1:0][3:0] hyst; // hysteresis per boundary
  logic [1:0] wsel; // accumulation window select
  logic [NSTEP-1:0][9:0] next_thr;
  logic [NSTEP-1:0][3:0] next_hyst;
  logic [1:0] next_wsel;
  logic [31:0] next_prdata;
  lqi_level_t next_worst;

  // measurement state
  lqi_state_t state;
  lqi_state_t next_state;
  logic [CNT_W-1:0] win_cnt; // cycles into the current window
  logic [CNT_W-1:0] next_win_cnt;
  logic [SUM_W-1:0] acc_sum; // error sum of the current window
  logic [SUM_W-1:0] next_acc_sum;
  logic [CNT_W-1:0] acc_num; // samples in the current window
  logic [CNT_W-1:0] next_acc_num;
  logic [SUM_W-1:0] quo; // dividend shifting into quotient
  logic [SUM_W-1:0] next_quo;
  logic [CNT_W:0] rem; // partial remainder
  logic [CNT_W:0] next_rem;
  logic [CNT_W-1:0] divisor;
  logic [CNT_W-1:0] next_divisor;
  logic [4:0] div_step; // divide iteration
  logic [4:0] next_div_step;
  lqi_level_t next_quality;
  lqi_mse_t next_average;

  // decoded strobes
  logic [2:0] slot;
  logic apb_access;
  logic apb_wr;
  logic status_rd;
  logic [CNT_W-1:0] win_len;
  logic win_end;
  logic div_done;
  logic [CNT_W:0] rem_shift;
  lqi_mse_t quo_mse;

  assign slot = reg_slot(paddr);
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite && (slot != 3'h7) && (slot != 3'h0);
  assign status_rd = apb_access && !pwrite && (slot == 3'h0);
  // zero wait state: read data was captured in the setup cycle
  assign pready = 1'b1;
  // unmapped words and writes to the read-only status answer with an error
  assign pslverr = apb_access && ((slot == 3'h7) || (pwrite && (slot == 3'h0)));

  // window length
  // doubling per select code keeps the 90/180/360/720 ratio exact
  assign win_len = CNT_W'(WIN_BASE_CYCLES) << wsel;
  // at or past the end: shrinking the window mid-count must not run the
  // counter round its whole range before the next close
  assign win_end = (win_cnt >= win_len - CNT_W'(1));
  assign div_done = (state == LQI_DIVIDE) && (div_step == 5'(SUM_W - 1));
  assign rem_shift = {rem[CNT_W-1:0], quo[SUM_W-1]};
  // average cannot exceed a sample, so the low ten bits hold it whole
  assign quo_mse = next_quo[9:0];

  // register file and worst-level tracking, next values
  always_comb begin
    next_thr = thr;
    next_hyst = hyst;
    next_wsel = wsel;
    next_prdata = prdata;
    next_worst = worst_level;
    // capture read data in the setup cycle so prdata leaves a flop
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (slot == 3'h0) begin
        next_prdata[`LQI_WORST_MSB:`LQI_WORST_LSB] = worst_level;
        next_prdata[`LQI_LEVEL_MSB:`LQI_LEVEL_LSB] = quality_level;
      end else if (slot != 3'h7) begin
        next_prdata[`LQI_HYST_MSB:`LQI_HYST_LSB] = hyst[slot-3'h1];
        next_prdata[`LQI_THR_MSB:`LQI_THR_LSB] = thr[slot-3'h1];
        // window select lives only in the first step register
        if (slot == 3'h1) next_prdata[`LQI_WSEL_MSB:`LQI_WSEL_LSB] = wsel;
      end
    end
    for (int i = 0; i < NSTEP; i++) begin
      if (apb_wr && (slot == 3'(i + 1))) begin
        if (pstrb[0]) next_thr[i][7:0] = pwdata[7:0];
        if (pstrb[1]) begin
          next_thr[i][9:8] = pwdata[9:8];
          next_hyst[i] = pwdata[`LQI_HYST_MSB:`LQI_HYST_LSB];
          if (i == 0) next_wsel = pwdata[`LQI_WSEL_MSB:`LQI_WSEL_LSB];
        end
      end
    end
    // poorest level tracking
    // a read restarts from the level in force after this edge, so a
    // drop landing on the read edge is kept for the next read
    if (status_rd) begin
      next_worst = div_done ? next_quality : quality_level;
    end else if (div_done && (next_quality < worst_level)) begin
      next_worst = next_quality;
    end
  end

  // register file and worst-level tracking, flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NSTEP; i++) begin
        // a call result cannot be part-selected, so cut by cast and shift
        thr[i] <= 10'(step_reset(i));
        hyst[i] <= 4'(step_reset(i) >> `LQI_HYST_LSB);
      end
      wsel <= 2'h0;
      prdata <= 32'h0000_0000;
      worst_level <= 3'h0;
    end else begin
      thr <= next_thr;
      hyst <= next_hyst;
      wsel <= next_wsel;
      prdata <= next_prdata;
      worst_level <= next_worst;
    end
  end

  // window accumulator and serial divider, next values
  always_comb begin
    next_state = state;
    next_win_cnt = win_cnt + CNT_W'(1);
    next_acc_sum = acc_sum;
    next_acc_num = acc_num;
    next_quo = quo;
    next_rem = rem;
    next_divisor = divisor;
    next_div_step = div_step;
    next_quality = quality_level;
    next_average = mse_average;
    if (mse_valid) begin
      next_acc_sum = acc_sum + SUM_W'(mse_value);
      next_acc_num = acc_num + CNT_W'(1);
    end
    // window close: hand the totals to the divider and restart
    if (win_end) begin
      next_win_cnt = '0;
      next_acc_sum = mse_valid ? SUM_W'(mse_value) : '0;
      next_acc_num = mse_valid ? CNT_W'(1) : '0;
    end
    case (state)
      LQI_ACCUM: begin
        // an empty window leaves the level untouched
        if (win_end && (acc_num != '0)) begin
          next_state = LQI_DIVIDE;
          next_quo = acc_sum;
          next_rem = '0;
          next_divisor = acc_num;
          next_div_step = 5'h00;
        end
      end
      LQI_DIVIDE: begin
        // one restoring step per clock; done far inside any window
        next_quo = {quo[SUM_W-2:0], 1'b0};
        next_rem = rem_shift;
        if (rem_shift >= {1'b0, divisor}) begin
          next_rem = rem_shift - {1'b0, divisor};
          next_quo[0] = 1'b1;
        end
        next_div_step = div_step + 5'h01;
        if (div_done) begin
          next_state = LQI_ACCUM;
          next_average = quo_mse;
          // map average to level with hysteresis
          next_quality = next_level(quo_mse, quality_level, thr, hyst);
        end
      end
      default: next_state = LQI_ACCUM;
    endcase
  end

  // window accumulator and serial divider, flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= LQI_ACCUM;
      win_cnt <= '0;
      acc_sum <= '0;
      acc_num <= '0;
      quo <= '0;
      rem <= '0;
      divisor <= '0;
      div_step <= 5'h00;
      quality_level <= 3'h0;
      mse_average <= 10'h000;
    end else begin
      state <= next_state;
      win_cnt <= next_win_cnt;
      acc_sum <= next_acc_sum;
      acc_num <= next_acc_num;
      quo <= next_quo;
      rem <= next_rem;
      divisor <= next_divisor;
      div_step <= next_div_step;
      quality_level <= next_quality;
      mse_average <= next_average;
    end
  end

  floor_band_a: assert property (@(posedge clk) disable iff (!reset_n)
    div_done && (quo_mse > 10'h066) |=> quality_level == 3'h0)
    else $error("average above floor edge did not give level 0");

  status_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    status_rd |-> (prdata[31:8] == 24'h0) && !prdata[4] && !prdata[0])
    else $error("status reserved bits not zero");

  divide_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state == LQI_ACCUM) && win_end && (acc_num != '0) |-> ##28 div_done)
    else $error("divider did not finish in its fixed step count");

  status_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    psel && !penable && (slot == 3'h0) && !pwrite ##1 status_rd
    |-> prdata[7:5] == $past(worst_level))
    else $error("status read did not show the tracked poorest level");

  worst_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
    status_rd |=> worst_level == quality_level)
    else $error("poorest level did not restart after status read");

  worst_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !status_rd |=> (worst_level <= $past(worst_level)) && (worst_level <= quality_level))
    else $error("poorest level rose without a read");

  window_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    win_end && $stable(wsel) |-> win_cnt == (CNT_W'(WIN_BASE_CYCLES) << wsel) - CNT_W'(1))
    else $error("window closed at the wrong count");

  thr_reset_a: assert property (@(posedge clk)
    $rose(reset_n) |-> (thr[0] == 10'h051) && (thr[1] == 10'h041) && (thr[2] == 10'h033)
      && (thr[3] == 10'h029) && (thr[4] == 10'h020) && (thr[5] == 10'h019))
    else $error("threshold reset values wrong");

  hyst_reset_a: assert property (@(posedge clk)
    $rose(reset_n) |-> (hyst[3:0] == {4{4'h3}}) && (hyst[5:4] == {2{4'h2}}))
    else $error("hysteresis reset values wrong");

  // the reset edge itself clears the level, so that edge is left out
  // level moves only on a finished average
  level_update_a: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && (quality_level != $past(quality_level)) |-> $past(div_done))
    else $error("level moved without a new average");

endmodule : lqi_link_quality

`default_nettype wire

// File: sim/tb_lqi_link_quality.sv
`timescale 1ns/10ps
`default_nettype none
`include "lqi_regs.svh"
module tb_lqi_link_quality
  import lqi_pkg::*;
;
  localparam int WB = 40; // short window keeps the run brief
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lqi_mse_t mse_value = 10'h067;
  logic mse_valid = 1'b1;
  lqi_level_t quality_level;
  lqi_level_t worst_level;
  lqi_mse_t mse_average;
  logic ramp = 1'b0; // error input counts up each cycle
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] rnd = 16'hF176; // seed
  logic [11:0] idx [7] = '{`LQI_IDX_STATUS, `LQI_IDX_STEP1, `LQI_IDX_STEP2,
    `LQI_IDX_STEP3, `LQI_IDX_STEP4, `LQI_IDX_STEP5, `LQI_IDX_STEP6};
  logic [15:0] m [7] = '{16'h0000, 16'h3051, 16'h3041, 16'h3033, 16'h3029,
    16'h2020, 16'h2019}; // register mirror
  int th [7] = '{102, 81, 65, 51, 41, 32, 25}; // level edges
  int hy [7] = '{0, 3, 3, 3, 3, 2, 2};
  lqi_level_t cur = '0; // expected level
  lqi_level_t worst = '0;
  lqi_mse_t pv = 10'h067; // value of the window still in flight
  lqi_mse_t tab1 [15] = '{102, 103, 81, 82, 65, 66, 51, 52, 41, 42, 32, 33, 25, 26, 0};
  lqi_mse_t tab2 [9] = '{100, 79, 78, 83, 85, 20, 27, 28, 103};
  logic [31:0] rd;
  logic er;
  int t [3];

  // clock, cycle count and error ramp
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (ramp) mse_value <= mse_value + 10'h001;

  lqi_link_quality #(.WIN_BASE_CYCLES(WB)) u_lqi_link_quality (.clk(clk),
    .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mse_value(mse_value),
    .mse_valid(mse_valid), .quality_level(quality_level),
    .worst_level(worst_level), .mse_average(mse_average));

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bus

  task automatic chk_mon(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_mon

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d,
    input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      test_done();
    end
  endtask : apb

  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // expected level: boundaries crossed in a row from the poorest end
  function automatic lqi_level_t lvl(input lqi_level_t c, input int a);
    lqi_level_t l;
    bit go;
    l = '0;
    go = 1'b1;
    for (int k = 0; k < 7; k++) begin
      if (go && ((k < c) ? (a <= th[k] + hy[k]) : (a + hy[k] <= th[k])))
        l = 3'(k + 1);
      else
        go = 1'b0;
    end
    return l;
  endfunction : lvl

  task automatic land(input int a);
    cur = lvl(cur, a);
    if (cur < worst) worst = cur;
  endtask : land

  task automatic wait_to(input int c);
    while (cyc < c) @(posedge clk);
  endtask : wait_to

  // wait for the first result of a pure window of value v
  task automatic sync(input lqi_mse_t v);
    int n;
    mse_value <= v;
    n = 0;
    while (mse_average !== v && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      errors++;
      test_done();
    end
    land(v);
    pv = v;
    repeat (2) @(posedge clk);
    #1;
  endtask : sync

  // two windows per value; samples paused around the boundary so none mix
  task automatic step(input lqi_mse_t v);
    int b;
    b = cyc;
    apb(1'b0, ba(`LQI_IDX_STATUS), 16'h0000, 4'h0);
    chk_bus("status", {24'h0, worst, 1'b0, cur, 1'b0}, rd);
    worst = cur;
    land(pv);
    wait_to(b + 6);
    mse_valid <= 1'b0;
    wait_to(b + 12);
    mse_value <= v;
    mse_valid <= 1'b1;
    wait_to(b + 79);
    #1;
    land(v);
    chk_mon("level", cur, quality_level);
    chk_mon("worst", worst, worst_level);
    chk_mon("average", v, mse_average);
    pv = v;
  endtask : step

  task automatic nxt(output int tc);
    lqi_mse_t a;
    int n;
    a = mse_average;
    n = 0;
    while (mse_average === a && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000) begin
      errors++;
      test_done();
    end
    tc = cyc;
  endtask : nxt

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ba(idx[i]), 16'h0000, 4'h0);
      chk_bus("reset value", {16'h0, m[i]}, rd);
    end
    // random writes; reserved bits of steps 2 to 6 stay zero
    for (int i = 1; i < 7; i++) begin
      rnd = lfsr(rnd);
      m[i] = (i == 1) ? rnd : (rnd & 16'hF3FF);
      apb(1'b1, ba(idx[i]), rnd, 4'h3);
      apb(1'b0, ba(idx[i]), 16'h0000, 4'h0);
      chk_bus("step rw", {16'h0, m[i]}, rd);
    end
    // low lane alone leaves hysteresis untouched
    apb(1'b1, ba(idx[3]), 16'hFFFF, 4'h1);
    apb(1'b0, ba(idx[3]), 16'h0000, 4'h0);
    chk_bus("lane0", {16'h0, m[3][15:8], 8'hFF}, rd);
    apb(1'b1, ba(idx[0]), 16'hFFFF, 4'h3);
    chk_bus("status write err", 32'h1, {31'h0, er});
    apb(1'b1, 16'h2000, 16'h0000, 4'h3);
    chk_bus("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, ba(idx[1]) + 16'h0002, 16'h0000, 4'h0);
    chk_bus("unaligned read", 32'h0, rd);
    // zero hysteresis exposes the bare band edges
    for (int i = 1; i < 7; i++) begin
      hy[i] = 0;
      apb(1'b1, ba(idx[i]), 16'(th[i]), 4'h3);
    end
    sync(10'h068);
    for (int i = 0; i < 15; i++) step(tab1[i]);
    $display("test band edges done");
    // second reset in mid-run restores the default hysteresis
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    cur = '0;
    worst = '0;
    hy = '{0, 3, 3, 3, 3, 2, 2};
    sync(10'h067);
    for (int i = 0; i < 9; i++) step(tab2[i]);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      step({3'b000, rnd[6:0]});
    end
    $display("test hysteresis done");
    ramp <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ba(idx[1]), {4'h3, 2'(s), 10'h051}, 4'h3);
      for (int k = 0; k < 3; k++) nxt(t[k]);
      chk_mon("window", 16'(WB << s), 16'(t[2] - t[1]));
    end
    $display("test window select done");
    test_done();
  end
endmodule : tb_lqi_link_quality
`default_nettype wire
